// *** hdl/mvs_pkg.sv ***
package mvs_pkg;

  // ==========================================================================
  // Register map, word addresses on the host port.
  localparam logic [11:0] ADR_CUR_RMS_RAW  = 12'h1cc;
  localparam logic [11:0] ADR_VOLT_RMS_RAW = 12'h1c8;
  localparam logic [11:0] ADR_REAL_PWR     = 12'h1d0;
  localparam logic [11:0] ADR_REACT_PWR    = 12'h1d4;
  localparam logic [11:0] ADR_APP_PWR      = 12'h1d8;
  localparam logic [11:0] ADR_ENERGY_RAW   = 12'h1dc;
  localparam logic [11:0] ADR_FUND_APP_ENR = 12'h1e0;
  localparam logic [11:0] ADR_VIRT_VOLT    = 12'h830;
  localparam logic [11:0] ADR_VIRT_CUR     = 12'h831;
  localparam logic [11:0] ADR_VIRT_REAL    = 12'h832;
  localparam logic [11:0] ADR_VIRT_REACT   = 12'h833;
  localparam logic [11:0] ADR_VIRT_APP     = 12'h834;
  localparam logic [11:0] ADR_VIRT_ENERGY  = 12'h835;
  localparam logic [11:0] ADR_CUR_COEF     = 12'h100;
  localparam logic [11:0] ADR_VOLT_COEF    = 12'h101;
  localparam logic [11:0] ADR_PWR_COEF     = 12'h102;
  localparam logic [11:0] ADR_ENR_COEF     = 12'h103;
  localparam logic [11:0] ADR_CONV_RATE    = 12'h104;
  localparam logic [11:0] ADR_OC_THR       = 12'h108;
  localparam logic [11:0] ADR_NO_LOAD_THR  = 12'h109;
  localparam logic [11:0] ADR_OV_THR       = 12'h10a;
  localparam logic [11:0] ADR_UV_THR       = 12'h10b;
  localparam logic [11:0] ADR_CONFIG       = 12'h10c;
  localparam logic [11:0] ADR_STATUS       = 12'h110;

  // ==========================================================================
  // Reset values, field positions and scaling.
  localparam logic [15:0] RST_COEF      = 16'h0000;
  localparam logic [15:0] RST_CONV_RATE = 16'h0167;
  localparam logic [15:0] RST_THR       = 16'h0000;
  localparam int          CFG_AH_BIT    = 0;
  localparam int          THR_MSB       = 23;
  localparam int          THR_LSB       = 8;
  localparam int          FRAC_SHIFT    = 4;
  localparam int          FRAME_MULT_SH = 3;

  // ==========================================================================
  // Carriers.
  typedef struct packed {
    logic [31:0] cur_rms;
    logic [31:0] volt_rms;
    logic [31:0] real_pwr;
    logic [31:0] react_pwr;
    logic [31:0] app_pwr;
    logic [31:0] energy;
    logic [31:0] fund_app_enr;
  } mvs_meas_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [11:0] addr;
    logic [31:0] wdata;
  } mvs_req_t;

  // Product of raw value and coefficient, with four fraction bits dropped.
  function automatic logic [31:0] scale(input logic [31:0] raw, input logic [15:0] coef);
    logic [47:0] prod;
    prod = 48'(raw) * 48'(coef);
    return prod[FRAC_SHIFT +: 32];
  endfunction

endpackage

// *** hdl/mvs_scaler.sv ***
`timescale 1ns/1ps
// Summary of operation
// RL1: Current raw LSB is full scale over 2^24.
// RL2: Voltage raw LSB is full scale over 2^24.
// RL3: Energy LSB is VFS*IFS*frame over 2^16.
// RL4: Power LSB is VFS*IFS over 2^32.
// RL5: Amp-hour accumulator LSB is IFS*frame over 2^16.
// RL6: Thresholds compare against RMS bits 23 to 8.
// RL7: Virtual reads return raw times coefficient.
// RL8: Separate power, voltage, current, energy coefficients.
// RL9: Host sets coefficient as weight over resolution.
// RL10: Host drops low 16 bits for units.
// RL11: Raw current 0x1cc, scaled current 0x831.
// RL12: Frame is (rate setting + 1) times eight clocks.
// RL13: Product truncated to 32 bits, fixed alignment.
module mvs_scaler
(
  input  wire logic              CLK_I,          // 10 MHz clock
  input  wire logic              RST_I,          // Asynchronous reset, active high
  input  wire mvs_pkg::mvs_req_t HOST_I,         // Host register request
  input  wire mvs_pkg::mvs_meas_t MEAS_I,        // Raw meter-unit results
  output logic                   ACK_O,          // Answer strobe, one cycle
  output logic [31:0]            RDATA_O,        // Read data, valid with ACK_O
  output logic                   FRAME_TICK_O,   // One pulse per frame
  output logic                   AH_MODE_O,      // Amp-hour accumulation selected
  output logic                   OC_O,           // Overcurrent level
  output logic                   OV_O,           // Overvoltage level
  output logic                   UV_O,           // Undervoltage level
  output logic                   NO_LOAD_O       // No-load level
);

  // ==========================================================================
  // State.
  typedef struct packed {
    logic [15:0] cur_coef;
    logic [15:0] volt_coef;
    logic [15:0] pwr_coef;
    logic [15:0] enr_coef;
    logic [15:0] rate;
    logic [15:0] oc_thr;
    logic [15:0] nl_thr;
    logic [15:0] ov_thr;
    logic [15:0] uv_thr;
    logic        ah_mode;
    logic        ack;
    logic [31:0] rdata;
    logic [18:0] frame_cnt;
    logic        frame_tick;
    logic        oc;
    logic        ov;
    logic        uv;
    logic        no_load;
  } mvs_state_t;

  mvs_state_t st_r;
  mvs_state_t st_nxt;
  logic [18:0] frame_last;
  logic [15:0] cur_lvl;
  logic [15:0] volt_lvl;
  logic [31:0] cur_w;
  logic [31:0] volt_w;
  logic [31:0] real_w;
  logic [31:0] enr_w;

  // The frame length in clocks is (rate + 1) * 8; its last count is rate * 8 + 7.
  assign frame_last = {st_r.rate, {mvs_pkg::FRAME_MULT_SH{1'b1}}};   // RL12
  assign cur_lvl    = MEAS_I.cur_rms[mvs_pkg::THR_MSB:mvs_pkg::THR_LSB];   // RL6 RL1
  assign volt_lvl   = MEAS_I.volt_rms[mvs_pkg::THR_MSB:mvs_pkg::THR_LSB];  // RL6 RL2
  assign cur_w      = MEAS_I.cur_rms;
  assign volt_w     = MEAS_I.volt_rms;
  assign real_w     = MEAS_I.real_pwr;
  assign enr_w      = MEAS_I.energy;

  // ==========================================================================
  // Next state.
  always_comb
  begin
    st_nxt     = st_r;
    st_nxt.ack = HOST_I.req;
    // Frame divider; a setting change moves the wrap of the current frame, or wraps at once if passed.
    if (st_r.frame_cnt >= frame_last)
    begin
      st_nxt.frame_cnt  = 19'h00000;
      st_nxt.frame_tick = 1'b1;                                   // RL12
      // Levels refresh once per frame, like a DSP cycle result.
      st_nxt.oc     = cur_lvl > st_r.oc_thr;                      // RL6
      st_nxt.no_load = cur_lvl < st_r.nl_thr;                     // RL6
      st_nxt.ov     = volt_lvl > st_r.ov_thr;                     // RL6
      st_nxt.uv     = !(volt_lvl > st_r.uv_thr);                  // RL6
    end
    else
    begin
      st_nxt.frame_cnt  = st_r.frame_cnt + 19'h00001;
      st_nxt.frame_tick = 1'b0;
    end
    st_nxt.rdata = 32'h0000_0000;
    if (HOST_I.req && HOST_I.we)
    begin
      case (HOST_I.addr)
        mvs_pkg::ADR_CUR_COEF:   st_nxt.cur_coef  = HOST_I.wdata[15:0];   // RL8
        mvs_pkg::ADR_VOLT_COEF:  st_nxt.volt_coef = HOST_I.wdata[15:0];   // RL8
        mvs_pkg::ADR_PWR_COEF:   st_nxt.pwr_coef  = HOST_I.wdata[15:0];   // RL8
        mvs_pkg::ADR_ENR_COEF:   st_nxt.enr_coef  = HOST_I.wdata[15:0];   // RL8
        mvs_pkg::ADR_CONV_RATE:  st_nxt.rate      = HOST_I.wdata[15:0];
        mvs_pkg::ADR_OC_THR:     st_nxt.oc_thr    = HOST_I.wdata[15:0];
        mvs_pkg::ADR_NO_LOAD_THR: st_nxt.nl_thr   = HOST_I.wdata[15:0];
        mvs_pkg::ADR_OV_THR:     st_nxt.ov_thr    = HOST_I.wdata[15:0];
        mvs_pkg::ADR_UV_THR:     st_nxt.uv_thr    = HOST_I.wdata[15:0];
        mvs_pkg::ADR_CONFIG:     st_nxt.ah_mode   = HOST_I.wdata[mvs_pkg::CFG_AH_BIT];
        default:                 st_nxt.ah_mode   = st_r.ah_mode;
      endcase
    end
    else if (HOST_I.req)
    begin
      // Raw reads pass meter units through; virtual reads go through the scaler.
      case (HOST_I.addr)
        mvs_pkg::ADR_CUR_RMS_RAW:  st_nxt.rdata = MEAS_I.cur_rms;            // RL11 RL1
        mvs_pkg::ADR_VOLT_RMS_RAW: st_nxt.rdata = MEAS_I.volt_rms;           // RL2
        mvs_pkg::ADR_REAL_PWR:     st_nxt.rdata = MEAS_I.real_pwr;           // RL4
        mvs_pkg::ADR_REACT_PWR:    st_nxt.rdata = MEAS_I.react_pwr;          // RL4
        mvs_pkg::ADR_APP_PWR:      st_nxt.rdata = MEAS_I.app_pwr;            // RL4
        mvs_pkg::ADR_ENERGY_RAW:   st_nxt.rdata = MEAS_I.energy;             // RL3
        mvs_pkg::ADR_FUND_APP_ENR: st_nxt.rdata = MEAS_I.fund_app_enr;       // RL3 RL5
        mvs_pkg::ADR_VIRT_CUR:
          st_nxt.rdata = mvs_pkg::scale(MEAS_I.cur_rms, st_r.cur_coef);      // RL7 RL11 RL13
        mvs_pkg::ADR_VIRT_VOLT:
          st_nxt.rdata = mvs_pkg::scale(MEAS_I.volt_rms, st_r.volt_coef);    // RL7 RL13
        mvs_pkg::ADR_VIRT_REAL:
          st_nxt.rdata = mvs_pkg::scale(MEAS_I.real_pwr, st_r.pwr_coef);     // RL7 RL8
        mvs_pkg::ADR_VIRT_REACT:
          st_nxt.rdata = mvs_pkg::scale(MEAS_I.react_pwr, st_r.pwr_coef);    // RL7 RL8
        mvs_pkg::ADR_VIRT_APP:
          st_nxt.rdata = mvs_pkg::scale(MEAS_I.app_pwr, st_r.pwr_coef);      // RL7 RL8
        mvs_pkg::ADR_VIRT_ENERGY:
          st_nxt.rdata = mvs_pkg::scale(MEAS_I.energy, st_r.enr_coef);       // RL7 RL8
        mvs_pkg::ADR_CUR_COEF:     st_nxt.rdata = {16'h0000, st_r.cur_coef};
        mvs_pkg::ADR_VOLT_COEF:    st_nxt.rdata = {16'h0000, st_r.volt_coef};
        mvs_pkg::ADR_PWR_COEF:     st_nxt.rdata = {16'h0000, st_r.pwr_coef};
        mvs_pkg::ADR_ENR_COEF:     st_nxt.rdata = {16'h0000, st_r.enr_coef};
        mvs_pkg::ADR_CONV_RATE:    st_nxt.rdata = {16'h0000, st_r.rate};
        mvs_pkg::ADR_OC_THR:       st_nxt.rdata = {16'h0000, st_r.oc_thr};
        mvs_pkg::ADR_NO_LOAD_THR:  st_nxt.rdata = {16'h0000, st_r.nl_thr};
        mvs_pkg::ADR_OV_THR:       st_nxt.rdata = {16'h0000, st_r.ov_thr};
        mvs_pkg::ADR_UV_THR:       st_nxt.rdata = {16'h0000, st_r.uv_thr};
        mvs_pkg::ADR_CONFIG:       st_nxt.rdata = {31'h00000000, st_r.ah_mode};
        mvs_pkg::ADR_STATUS:       st_nxt.rdata = {28'h0000000, st_r.no_load, st_r.uv,
                                                   st_r.ov, st_r.oc};
        default:                   st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Registers.
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      st_r           <= '0;
      st_r.cur_coef  <= mvs_pkg::RST_COEF;
      st_r.volt_coef <= mvs_pkg::RST_COEF;
      st_r.pwr_coef  <= mvs_pkg::RST_COEF;
      st_r.enr_coef  <= mvs_pkg::RST_COEF;
      st_r.rate      <= mvs_pkg::RST_CONV_RATE;                    // RL12
      st_r.oc_thr    <= mvs_pkg::RST_THR;
      st_r.nl_thr    <= mvs_pkg::RST_THR;
      st_r.ov_thr    <= mvs_pkg::RST_THR;
      st_r.uv_thr    <= mvs_pkg::RST_THR;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign ACK_O        = st_r.ack;
  assign RDATA_O      = st_r.rdata;
  assign FRAME_TICK_O = st_r.frame_tick;
  assign AH_MODE_O    = st_r.ah_mode;
  assign OC_O         = st_r.oc;
  assign OV_O         = st_r.ov;
  assign UV_O         = st_r.uv;
  assign NO_LOAD_O    = st_r.no_load;

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sequence rd_at(logic [11:0] a);
    HOST_I.req && !HOST_I.we && HOST_I.addr == a;
  endsequence

  sequence frame_wrap;
    st_r.frame_cnt >= frame_last;
  endsequence

  read_answer_a: assert property (HOST_I.req |=> ACK_O)                   // RL7
    else $error("Request not answered next cycle");
  answer_pulse_a: assert property (!HOST_I.req |=> !ACK_O)                // RL7
    else $error("Answer without request");
  raw_current_a: assert property (rd_at(mvs_pkg::ADR_CUR_RMS_RAW)         // RL11
    |=> RDATA_O == $past(cur_w))
    else $error("Raw current read wrong");
  virt_current_a: assert property (rd_at(mvs_pkg::ADR_VIRT_CUR)           // RL13
    |=> RDATA_O == mvs_pkg::scale($past(cur_w), $past(st_r.cur_coef)))
    else $error("Scaled current read wrong");
  virt_voltage_a: assert property (rd_at(mvs_pkg::ADR_VIRT_VOLT)          // RL7
    |=> RDATA_O == mvs_pkg::scale($past(volt_w), $past(st_r.volt_coef)))
    else $error("Scaled voltage read wrong");
  virt_power_a: assert property (rd_at(mvs_pkg::ADR_VIRT_REAL)            // RL8
    |=> RDATA_O == mvs_pkg::scale($past(real_w), $past(st_r.pwr_coef)))
    else $error("Scaled power read wrong");
  virt_energy_a: assert property (rd_at(mvs_pkg::ADR_VIRT_ENERGY)         // RL3
    |=> RDATA_O == mvs_pkg::scale($past(enr_w), $past(st_r.enr_coef)))
    else $error("Scaled energy read wrong");
  frame_gap_a: assert property (FRAME_TICK_O |=> !FRAME_TICK_O [*7])      // RL12
    else $error("Frame shorter than eight clocks");
  frame_wrap_a: assert property (frame_wrap |=> FRAME_TICK_O)             // RL12
    else $error("Frame tick missing at wrap");
  overcurrent_a: assert property (frame_wrap                              // RL6
    |=> OC_O == ($past(cur_lvl) > $past(st_r.oc_thr)))
    else $error("Overcurrent level wrong");
  undervoltage_a: assert property (frame_wrap                             // RL6
    |=> UV_O == !($past(volt_lvl) > $past(st_r.uv_thr)))
    else $error("Undervoltage level wrong");
  overvoltage_a: assert property (frame_wrap                              // RL6
    |=> OV_O == ($past(volt_lvl) > $past(st_r.ov_thr)))
    else $error("Overvoltage level wrong");
  no_load_a: assert property (frame_wrap                                  // RL6
    |=> NO_LOAD_O == ($past(cur_lvl) < $past(st_r.nl_thr)))
    else $error("No-load level wrong");
  // Levels are frame results; a change between wraps would look like a glitch to the host.
  flags_hold_a: assert property (!(st_r.frame_cnt >= frame_last)          // RL6
    |=> $stable({OC_O, OV_O, UV_O, NO_LOAD_O}))
    else $error("Level changed between frame wraps");
  status_read_a: assert property (rd_at(mvs_pkg::ADR_STATUS)              // RL6
    |=> RDATA_O == {28'h0000000, $past(NO_LOAD_O), $past(UV_O), $past(OV_O), $past(OC_O)})
    else $error("Status read wrong");

  // ==========================================================================
  // Frame divider.
  tick_at_wrap_a: assert property (!(st_r.frame_cnt >= frame_last)        // RL12
    |=> !FRAME_TICK_O)
    else $error("Frame tick without wrap");
  frame_restart_a: assert property (FRAME_TICK_O |-> st_r.frame_cnt == 19'h00000) // RL12
    else $error("Counter not restarted with tick");

  // ==========================================================================
  // Register writes, plain reads and the reactive and apparent scaled reads.
  sequence wr_at(logic [11:0] a);
    HOST_I.req && HOST_I.we && HOST_I.addr == a;
  endsequence

  rate_write_a: assert property (wr_at(mvs_pkg::ADR_CONV_RATE)            // RL12
    |=> st_r.rate == $past(HOST_I.wdata[15:0]))
    else $error("Rate setting not taken");
  cur_coef_a: assert property (wr_at(mvs_pkg::ADR_CUR_COEF)               // RL8
    |=> st_r.cur_coef == $past(HOST_I.wdata[15:0]))
    else $error("Current coefficient not taken");
  volt_coef_a: assert property (wr_at(mvs_pkg::ADR_VOLT_COEF)             // RL8
    |=> st_r.volt_coef == $past(HOST_I.wdata[15:0]))
    else $error("Voltage coefficient not taken");
  pwr_coef_a: assert property (wr_at(mvs_pkg::ADR_PWR_COEF)               // RL8
    |=> st_r.pwr_coef == $past(HOST_I.wdata[15:0]))
    else $error("Power coefficient not taken");
  enr_coef_a: assert property (wr_at(mvs_pkg::ADR_ENR_COEF)               // RL8
    |=> st_r.enr_coef == $past(HOST_I.wdata[15:0]))
    else $error("Energy coefficient not taken");
  amp_hour_a: assert property (wr_at(mvs_pkg::ADR_CONFIG)                 // RL5
    |=> AH_MODE_O == $past(HOST_I.wdata[mvs_pkg::CFG_AH_BIT]))
    else $error("Amp-hour mode not taken");
  coef_read_a: assert property (rd_at(mvs_pkg::ADR_CUR_COEF)              // RL8
    |=> RDATA_O == {16'h0000, $past(st_r.cur_coef)})
    else $error("Coefficient read wrong");
  // Stale data on a write would pass for an answer with a host that ignores the direction.
  write_quiet_a: assert property (HOST_I.req && HOST_I.we                 // RL7
    |=> RDATA_O == 32'h0000_0000)
    else $error("Read data on a write");
  rdata_idle_a: assert property (!HOST_I.req |=> RDATA_O == 32'h0000_0000) // RL7
    else $error("Read data without request");
  raw_voltage_a: assert property (rd_at(mvs_pkg::ADR_VOLT_RMS_RAW)        // RL2
    |=> RDATA_O == $past(volt_w))
    else $error("Raw voltage read wrong");
  raw_power_a: assert property (rd_at(mvs_pkg::ADR_REAL_PWR)              // RL4
    |=> RDATA_O == $past(real_w))
    else $error("Raw real power read wrong");
  raw_react_a: assert property (rd_at(mvs_pkg::ADR_REACT_PWR)             // RL4
    |=> RDATA_O == $past(MEAS_I.react_pwr))
    else $error("Raw reactive power read wrong");
  raw_apparent_a: assert property (rd_at(mvs_pkg::ADR_APP_PWR)            // RL4
    |=> RDATA_O == $past(MEAS_I.app_pwr))
    else $error("Raw apparent power read wrong");
  raw_energy_a: assert property (rd_at(mvs_pkg::ADR_ENERGY_RAW)           // RL3
    |=> RDATA_O == $past(enr_w))
    else $error("Raw energy read wrong");
  fund_energy_a: assert property (rd_at(mvs_pkg::ADR_FUND_APP_ENR)        // RL5
    |=> RDATA_O == $past(MEAS_I.fund_app_enr))
    else $error("Fundamental apparent energy read wrong");
  // The power classes share one coefficient, so a slip in the decode shows up here.
  virt_react_a: assert property (rd_at(mvs_pkg::ADR_VIRT_REACT)           // RL8
    |=> RDATA_O == mvs_pkg::scale($past(MEAS_I.react_pwr), $past(st_r.pwr_coef)))
    else $error("Scaled reactive power read wrong");
  virt_apparent_a: assert property (rd_at(mvs_pkg::ADR_VIRT_APP)          // RL8
    |=> RDATA_O == mvs_pkg::scale($past(MEAS_I.app_pwr), $past(st_r.pwr_coef)))
    else $error("Scaled apparent power read wrong");

endmodule

// *** dv/mvs_host_model.sv ***
`timescale 1ns/1ps
module mvs_host_model
(
  input  wire logic         clk_i,   // Scaler clock
  input  wire logic         ack_i,   // Answer strobe
  input  wire logic [31:0]  rdata_i, // Read data
  output mvs_pkg::mvs_req_t host_o   // Request to the scaler
);
  // ==========================================================================
  // Bus cycle.
  initial host_o = '0;

  // The strobe lasts one cycle, since holding it would be taken as a second access.
  // The idle fields are inverted so that a decode that ignores the strobe shows up.
  task automatic xfer(input logic we, input logic [11:0] a, input logic [31:0] d,
                      output logic ack, output logic [31:0] q);
    @(posedge clk_i);
    host_o <= '{req: 1'b1, we: we, addr: a, wdata: d};
    @(posedge clk_i);
    host_o <= '{req: 1'b0, we: ~we, addr: ~a, wdata: ~d};
    @(posedge clk_i);
    ack = ack_i;
    q = rdata_i;
  endtask

  // ==========================================================================
  // Host arithmetic.
  function automatic logic [15:0] coef_for(input int fs, input int lsb);
    return 16'(fs / (lsb * 256));
  endfunction

  function automatic logic [15:0] whole_units(input logic [31:0] v);
    return v[31:16];
  endfunction
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic               clk;
  logic               rst;
  mvs_pkg::mvs_req_t  host;
  mvs_pkg::mvs_meas_t meas;
  logic               ack;
  logic [31:0]        rdata;
  logic               tick;
  logic               ah;
  logic               oc;
  logic               ov;
  logic               uv;
  logic               nl;
  int                 n_errors = 0;
  int                 cmp_count = 0;

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  mvs_scaler uut (.CLK_I(clk), .RST_I(rst), .HOST_I(host), .MEAS_I(meas), .ACK_O(ack),
    .RDATA_O(rdata), .FRAME_TICK_O(tick), .AH_MODE_O(ah), .OC_O(oc), .OV_O(ov), .UV_O(uv),
    .NO_LOAD_O(nl));
  mvs_host_model hm (.clk_i(clk), .ack_i(ack), .rdata_i(rdata), .host_o(host));

  // ==========================================================================
  // Shared tasks.
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task rd(input logic [11:0] a, output logic [31:0] q);
    logic k;
    hm.xfer(1'b0, a, 32'h0, k, q);
    check({31'h0, k}, 32'h1);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic        k;
    logic [31:0] q;
    hm.xfer(1'b1, a, d, k, q);
    check({31'h0, k}, 32'h1);
    check(q, 32'h0);
  endtask

  function automatic logic [31:0] sc(input logic [31:0] r, input logic [15:0] c);
    logic [47:0] p;
    p = {16'h0, r} * {32'h0, c};
    return p[35:4];
  endfunction

  // Counts edges from one frame tick to the next; returns at the second tick's edge.
  task per(output int p);
    repeat (200)
    begin
      @(posedge clk);
      if (tick === 1'b1) break;
    end
    p = 0;
    repeat (200)
    begin
      @(posedge clk);
      p++;
      if (tick === 1'b1) break;
    end
  endtask

  // ==========================================================================
  // Scenarios.
  task t_reset;
    logic [11:0] ra [12] = '{12'h100, 12'h101, 12'h102, 12'h103, 12'h104, 12'h108, 12'h109,
                             12'h10a, 12'h10b, 12'h10c, 12'h110, 12'h7ff};
    logic [31:0] q;
    foreach (ra[i])
    begin
      rd(ra[i], q);
      check(q, (ra[i] == 12'h104) ? 32'h00000167 : 32'h0);
    end
    $display("test reset done");
  endtask

  task t_virt;
    logic [11:0] va [6] = '{12'h830, 12'h831, 12'h832, 12'h833, 12'h834, 12'h835};
    logic [11:0] ra [6] = '{12'h1c8, 12'h1cc, 12'h1d0, 12'h1d4, 12'h1d8, 12'h1dc};
    logic [15:0] cf [6];
    logic [31:0] rv [6];
    logic [31:0] q;
    cf = '{16'h0011, hm.coef_for(102400, 1), 16'h0022, 16'h0022, 16'h0022, 16'h0033};
    rv = '{meas.volt_rms, meas.cur_rms, meas.real_pwr, meas.react_pwr, meas.app_pwr,
           meas.energy};
    wr(12'h100, {16'h0, cf[1]});
    wr(12'h101, 32'h11);
    wr(12'h102, 32'h22);
    wr(12'h103, 32'h33);
    wr(12'h1cc, 32'h0);
    rd(12'h831, q);
    check(q, 32'hb8e45170);
    check({16'h0, hm.whole_units(q)}, 32'd47332);
    foreach (va[i])
    begin
      rd(va[i], q);
      check(q, sc(rv[i], cf[i]));
      rd(ra[i], q);
      check(q, rv[i]);
    end
    rd(12'h1e0, q);
    check(q, meas.fund_app_enr);
    $display("test virtual done");
  endtask

  task t_frame;
    int p;
    wr(12'h104, 32'h0);
    per(p);
    check(32'(p), 32'd8);
    wr(12'h104, 32'h2);
    per(p);
    check(32'(p), 32'd24);
    wr(12'h104, 32'h0);
    $display("test frame done");
  endtask

  task thr(input logic [15:0] toc, tov, tuv, tnl, input logic [3:0] e);
    int          p;
    logic [31:0] q;
    wr(12'h108, {16'h0, toc});
    wr(12'h10a, {16'h0, tov});
    wr(12'h10b, {16'h0, tuv});
    wr(12'h109, {16'h0, tnl});
    per(p);
    per(p);
    check({28'h0, nl, uv, ov, oc}, {28'h0, e});
    rd(12'h110, q);
    check(q, {28'h0, e});
  endtask

  task t_flags;
    logic [31:0] q;
    thr(16'h6549, 16'h6e16, 16'h6e16, 16'h654b, 4'b1101);
    thr(16'h654a, 16'h6e15, 16'h6e15, 16'h654a, 4'b0010);
    wr(12'h10c, 32'h1);
    check({31'h0, ah}, 32'h1);
    rd(12'h10c, q);
    check(q, 32'h1);
    wr(12'h10c, 32'h0);
    check({31'h0, ah}, 32'h0);
    $display("test flags done");
  endtask

  // Reset in mid-run, with every setting moved away from its reset value beforehand.
  task t_rerst;
    wr(12'h10c, 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    check({31'h0, ah}, 32'h0);
    check({28'h0, nl, uv, ov, oc}, 32'h0);
    t_reset();
    $display("test mid-run reset done");
  endtask

  // ==========================================================================
  // Closing and main sequence.
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    rst = 1'b1;
    meas = '{cur_rms: 32'h07654af0, volt_rms: 32'h006e1679, real_pwr: 32'h00123456,
             react_pwr: 32'h00abcdef, app_pwr: 32'h01000000, energy: 32'h00000fff,
             fund_app_enr: 32'h00020000};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_virt();
    t_frame();
    t_flags();
    t_rerst();
    results();
  end

  // The tests need a few hundred cycles; this allows about a hundred times that.
  initial
  begin
    #3000000;
    n_errors++;
    results();
  end
endmodule
